/* File: logic/sirq_clkgen.sv */
// Serial clock output with restart at normal duty
`timescale 1ns/100ps
module sirq_clkgen
	import sirq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic idle_level,
	input wire logic drive,
	input wire logic [DIV_W-1:0] half_period,
	// Pin
	output logic sck_o_q,
	output logic sck_oe_n_q
);

	sirq_ck_state_t state_q;
	logic [DIV_W-1:0] cnt_q;
	logic last;

	assign last = (cnt_q + 8'h01) >= half_period;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CK_STOP;
		end else if (ce) begin
			case (state_q)
				CK_STOP: begin
					if (run) begin
						state_q <= CK_RUN;
					end
				end
				CK_RUN: begin
					if (!run) begin
						state_q <= CK_STOP;
					end
				end
				default: begin
					state_q <= CK_STOP;
				end
			endcase
		end
	end

	// Restart begins a full half period at the idle level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			sck_o_q <= 1'b0;
		end else if (ce) begin
			if (restart || state_q == CK_STOP || !run) begin
				cnt_q <= 8'h00;
				sck_o_q <= idle_level;
			end else if (last) begin
				cnt_q <= 8'h00;
				sck_o_q <= ~sck_o_q;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_oe_n_q <= 1'b1;
		end else if (ce) begin
			sck_oe_n_q <= ~(run | drive);
		end
	end

endmodule

/* File: logic/sirq_pkg.sv */
// Constants and register map of the serial unit request logic
// Function
// - Writing 1 to clock_output_enable restarts the serial clock with normal duty
// - Each request has its own vector; rx_full_request and rx_error_request share rx_irq_enable
// - tx_empty_request is raised while tx_data_empty_flag is 1
// - tx_end_request only while tx_end_flag and tx_end_irq_enable are both 1
// - tx_empty_request may start the transfer controller; its write clears tx_data_empty_flag
// - rx_full_request is raised while rx_full_flag is 1
// - rx_error_request on overrun, parity or framing flag; never to transfer controller
// - rx_full_request may start the transfer controller; its read clears rx_full_flag
// - tx_empty_request wins acceptance over a pending tx_end_request
// - Clearing both transmit flags removes tx_end_request until tx_end_flag is set again
// - rx_error_request is gated by rx_irq_enable
// - tx_empty_request is gated by tx_irq_enable
package sirq_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_VECTOR = 8'h10;
	localparam logic [7:0] OFS_CLKDIV = 8'h14;

	// Control register fields
	localparam int CTL_TX_IRQ_EN = 0;
	localparam int CTL_RX_IRQ_EN = 1;
	localparam int CTL_TX_END_IRQ_EN = 2;
	localparam int CTL_CLK_OUT_EN = 3;
	localparam int CTL_SCK_IDLE = 4;
	localparam int CTL_TX_TC_SEL = 5;
	localparam int CTL_RX_TC_SEL = 6;
	localparam int CTL_SCK_DRIVE = 7;
	localparam int CTL_W = 8;
	localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

	// Status register fields
	localparam int ST_TX_DATA_EMPTY_FLAG = 0;
	localparam int ST_TX_END_FLAG = 1;
	localparam int ST_RX_FULL_FLAG = 2;
	localparam int ST_OVERRUN_FLAG = 3;
	localparam int ST_PER = 4;
	localparam int ST_FER = 5;
	localparam int ST_W = 6;
	localparam logic [ST_W-1:0] ST_RESET = 6'h03;

	// Request indices, shared by interrupt status, mask and vector
	localparam int RQ_ERR = 0;
	localparam int RQ_RXF = 1;
	localparam int RQ_TXE = 2;
	localparam int RQ_TX_END_FLAG = 3;
	localparam int RQ_W = 4;
	localparam logic [RQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	// Vector codes, one per source
	localparam logic [1:0] VEC_ERR = 2'h0;
	localparam logic [1:0] VEC_RXF = 2'h1;
	localparam logic [1:0] VEC_TXE = 2'h2;
	localparam logic [1:0] VEC_TX_END_FLAG = 2'h3;

	// Serial clock half period in pclk cycles
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] CLKDIV_RESET = 8'h04;

	typedef enum logic [0:0] {
		CK_STOP = 1'b0,
		CK_RUN = 1'b1
	} sirq_ck_state_t;

endpackage

/* File: logic/sirq_prio.sv */
// Fixed priority selection of the pending request vector
`timescale 1ns/100ps
module sirq_prio
	import sirq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Pending requests
	input wire logic [RQ_W-1:0] pending,
	// Selected vector
	output logic vec_valid_q,
	output logic [1:0] vec_code_q
);

	logic [1:0] code_d;

	// Transmit empty is ahead of transmit end
	always_comb begin
		code_d = VEC_ERR;
		if (pending[RQ_ERR]) begin
			code_d = VEC_ERR;
		end else if (pending[RQ_RXF]) begin
			code_d = VEC_RXF;
		end else if (pending[RQ_TXE]) begin
			code_d = VEC_TXE;
		end else if (pending[RQ_TX_END_FLAG]) begin
			code_d = VEC_TX_END_FLAG;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_valid_q <= 1'b0;
			vec_code_q <= VEC_ERR;
		end else if (ce) begin
			vec_valid_q <= |pending;
			vec_code_q <= code_d;
		end
	end

endmodule

/* File: logic/sirq_top.sv */
// Request, interrupt and clock control logic of the serial unit
`timescale 1ns/100ps
module sirq_top
	import sirq_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flag set events from the transmit and receive datapath
	input wire logic tx_data_empty_flag_set,
	input wire logic tx_end_flag_set,
	input wire logic rx_full_flag_set,
	input wire logic overrun_flag_set,
	input wire logic per_set,
	input wire logic fer_set,
	// Transfer controller accesses to the data registers
	input wire logic tc_tx_write,
	input wire logic tc_rx_read,
	// Power state
	input wire logic standby_active,
	// Requests to the interrupt controller
	output logic tx_empty_request,
	output logic tx_end_request,
	output logic rx_full_request,
	output logic rx_error_request,
	output logic req_vec_valid,
	output logic [1:0] req_vec_code,
	// Activation requests to the transfer controller
	output logic tc_tx_activate,
	output logic tc_rx_activate,
	// Summary interrupt
	output logic irq,
	// Serial clock pin
	output logic sck_o,
	output logic sck_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Hardware set has precedence over any clear in the same cycle
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction

	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h000000, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic hit;
	logic wr_ctrl;
	logic wr_status;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic wr_clkdiv;

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_en = access_ph & pwrite & ce;

	always_comb begin
		case (paddr)
			OFS_CTRL: hit = 1'b1;
			OFS_STATUS: hit = 1'b1;
			OFS_IRQ_STAT: hit = 1'b1;
			OFS_IRQ_MASK: hit = 1'b1;
			OFS_VECTOR: hit = 1'b1;
			OFS_CLKDIV: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	assign wr_ctrl = wr_en & (paddr == OFS_CTRL);
	assign wr_status = wr_en & (paddr == OFS_STATUS);
	assign wr_irq_stat = wr_en & (paddr == OFS_IRQ_STAT);
	assign wr_irq_mask = wr_en & (paddr == OFS_IRQ_MASK);
	assign wr_clkdiv = wr_en & (paddr == OFS_CLKDIV);

	assign pready = 1'b1;
	assign pslverr = access_ph & ~hit;

	////////////////////////////////////////////////////////////////////////////////
	// Control register

	logic [CTL_W-1:0] ctrl_q;
	logic clk_restart_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[CTL_W-1:0];
		end
	end

	// Every write of a one to the clock enable restarts the clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_restart_q <= 1'b0;
		end else if (ce) begin
			clk_restart_q <= wr_ctrl & pwdata[CTL_CLK_OUT_EN];
		end
	end

	logic [DIV_W-1:0] clkdiv_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkdiv_q <= CLKDIV_RESET;
		end else if (wr_clkdiv) begin
			clkdiv_q <= pwdata[DIV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags

	logic [ST_W-1:0] st_q;
	logic [ST_W-1:0] st_clr;
	logic [ST_W-1:0] st_set;

	assign st_set = {fer_set, per_set, overrun_flag_set, rx_full_flag_set, tx_end_flag_set, tx_data_empty_flag_set};

	// Software clears by writing one; transfer controller clears its own flag
	always_comb begin
		st_clr = wr_status ? pwdata[ST_W-1:0] : 6'h00;
		st_clr[ST_TX_DATA_EMPTY_FLAG] = st_clr[ST_TX_DATA_EMPTY_FLAG] | tc_tx_write;
		st_clr[ST_RX_FULL_FLAG] = st_clr[ST_RX_FULL_FLAG] | tc_rx_read;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_RESET;
		end else if (ce) begin
			for (int i = 0; i < ST_W; i++) begin
				st_q[i] <= flag_next(st_q[i], st_set[i], st_clr[i]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request generation

	logic txe_src;
	logic tx_end_flag_src;
	logic rxf_src;
	logic err_src;
	logic txe_q;
	logic tx_end_flag_q;
	logic rxf_q;
	logic err_q;

	assign txe_src = st_q[ST_TX_DATA_EMPTY_FLAG] & ctrl_q[CTL_TX_IRQ_EN];
	assign tx_end_flag_src = st_q[ST_TX_END_FLAG] & ctrl_q[CTL_TX_END_IRQ_EN];
	assign rxf_src = st_q[ST_RX_FULL_FLAG] & ctrl_q[CTL_RX_IRQ_EN];
	assign err_src = (st_q[ST_OVERRUN_FLAG] | st_q[ST_PER] | st_q[ST_FER]) & ctrl_q[CTL_RX_IRQ_EN];

	// Registered levels follow source and enable one cycle later
	// Transmit empty, may go to the transfer controller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txe_q <= 1'b0;
		end else if (ce) begin
			txe_q <= txe_src;
		end
	end

	// Transmit end, CPU only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_end_flag_q <= 1'b0;
		end else if (ce) begin
			tx_end_flag_q <= tx_end_flag_src;
		end
	end

	// Receive full, may go to the transfer controller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxf_q <= 1'b0;
		end else if (ce) begin
			rxf_q <= rxf_src;
		end
	end

	// Receive error, CPU only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0;
		end else if (ce) begin
			err_q <= err_src;
		end
	end

	// Transfer controller only ever sees the two data requests
	assign tc_tx_activate = txe_q & ctrl_q[CTL_TX_TC_SEL];
	assign tc_rx_activate = rxf_q & ctrl_q[CTL_RX_TC_SEL];
	assign tx_empty_request = txe_q & ~ctrl_q[CTL_TX_TC_SEL];
	assign rx_full_request = rxf_q & ~ctrl_q[CTL_RX_TC_SEL];
	assign tx_end_request = tx_end_flag_q;
	assign rx_error_request = err_q;

	logic [RQ_W-1:0] pending;

	always_comb begin
		pending = 4'h0;
		pending[RQ_ERR] = rx_error_request;
		pending[RQ_RXF] = rx_full_request;
		pending[RQ_TXE] = tx_empty_request;
		pending[RQ_TX_END_FLAG] = tx_end_request;
	end

	sirq_prio u_prio (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pending(pending),
		.vec_valid_q(req_vec_valid),
		.vec_code_q(req_vec_code)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sticky interrupt status and mask

	logic [RQ_W-1:0] pend_prev_q;
	logic [RQ_W-1:0] irq_ev;
	logic [RQ_W-1:0] irq_stat_q;
	logic [RQ_W-1:0] irq_mask_q;
	logic [RQ_W-1:0] irq_clr;

	assign irq_ev = pending & ~pend_prev_q;
	assign irq_clr = wr_irq_stat ? pwdata[RQ_W-1:0] : 4'h0;

	// Events are rising edges of the CPU-bound requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_prev_q <= 4'h0;
		end else if (ce) begin
			pend_prev_q <= pending;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 4'h0;
		end else if (ce) begin
			for (int i = 0; i < RQ_W; i++) begin
				irq_stat_q[i] <= flag_next(irq_stat_q[i], irq_ev[i], irq_clr[i]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (wr_irq_mask) begin
			irq_mask_q <= pwdata[RQ_W-1:0];
		end
	end

	// Summary level follows the sticky bits one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup cycle

	logic [31:0] rd_d;

	always_comb begin
		case (paddr)
			OFS_CTRL: rd_d = zext8(ctrl_q);
			OFS_STATUS: rd_d = {26'h0000000, st_q};
			OFS_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
			OFS_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
			OFS_VECTOR: rd_d = {29'h00000000, req_vec_valid, req_vec_code};
			OFS_CLKDIV: rd_d = zext8(clkdiv_q);
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (ce && setup_ph) begin
			prdata <= pwrite ? 32'h00000000 : rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock output

	logic standby_meta_q;
	logic standby_q;
	logic clk_run;

	// Standby comes from the power controller, outside this clock's domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_meta_q <= 1'b0;
			standby_q <= 1'b0;
		end else if (ce) begin
			standby_meta_q <= standby_active;
			standby_q <= standby_meta_q;
		end
	end

	// Held while in standby, so software leaves standby before it re-enables
	assign clk_run = ctrl_q[CTL_CLK_OUT_EN] & ~standby_q;

	sirq_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(clk_run),
		.restart(clk_restart_q),
		.idle_level(ctrl_q[CTL_SCK_IDLE]),
		.drive(ctrl_q[CTL_SCK_DRIVE]),
		.half_period(clkdiv_q),
		.sck_o_q(sck_o),
		.sck_oe_n_q(sck_oe_n)
	);

endmodule

/* File: sim/sirq_chk.sv */
// Concurrent checks on the request outputs of the serial unit
`timescale 1ns/100ps
module sirq_chk
	import sirq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus and flag events
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic tx_data_empty_flag_set,
	input wire logic overrun_flag_set,
	input wire logic per_set,
	input wire logic fer_set,
	input wire logic tc_tx_write,
	// Requests
	input wire logic tx_empty_request,
	input wire logic tx_end_request,
	input wire logic rx_full_request,
	input wire logic rx_error_request,
	input wire logic req_vec_valid,
	input wire logic [1:0] req_vec_code,
	input wire logic tc_tx_activate
);
	logic wr;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////
	chk_txe_rise: assert property ($rose(tx_empty_request) |-> $past(tx_data_empty_flag_set, 2) || $past(wr, 2))
		else $error("tx empty request rose without cause");
	chk_err_rise: assert property ($rose(rx_error_request) |-> $past(overrun_flag_set || per_set || fer_set, 2) || $past(wr, 2))
		else $error("rx error request rose without cause");
	chk_txe_fall: assert property ($fell(tx_empty_request) |-> $past(wr, 2) || $past(tc_tx_write, 2))
		else $error("tx empty request dropped without cause");
	chk_tx_end_flag_fall: assert property ($fell(tx_end_request) |-> $past(wr, 2))
		else $error("tx end request dropped without cause");
	chk_tc_clear: assert property ((tc_tx_write && !tx_data_empty_flag_set) ##1 !tx_data_empty_flag_set |=> !tc_tx_activate)
		else $error("transfer write left activation high");
	chk_vec_txe: assert property (req_vec_valid && req_vec_code == VEC_TXE
		|-> $past(tx_empty_request) && !$past(rx_full_request || rx_error_request))
		else $error("tx empty vector wrong");
	chk_vec_tx_end_flag: assert property (req_vec_valid && req_vec_code == VEC_TX_END_FLAG
		|-> $past(tx_end_request) && !$past(tx_empty_request))
		else $error("tx end vector taken over tx empty");
	chk_vec_err: assert property (rx_error_request |=> req_vec_valid && req_vec_code == VEC_ERR)
		else $error("error vector missing");
	cover property (tc_tx_write);
	cover property ($rose(tx_end_request));
	cover property (rx_error_request && rx_full_request);
endmodule
bind sirq_top sirq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .tx_data_empty_flag_set, .overrun_flag_set, .per_set,
	.fer_set, .tc_tx_write, .tx_empty_request, .tx_end_request, .rx_full_request, .rx_error_request,
	.req_vec_valid, .req_vec_code, .tc_tx_activate);

/* File: sim/sirq_tc_model.sv */
// Transfer controller model answering activation requests
`timescale 1ns/100ps
module sirq_tc_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Answer 2 or 6 cycles after activation
	input wire logic slow,
	// Activation and data access
	input wire logic tx_act,
	input wire logic rx_act,
	output logic tx_wr,
	output logic rx_rd
);
	logic [2:0] tc_q;
	logic [2:0] rc_q;
	// One access per activation, counter saturates until it drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_q <= 3'h0;
			rc_q <= 3'h0;
			tx_wr <= 1'b0;
			rx_rd <= 1'b0;
		end else begin
			tc_q <= !tx_act ? 3'h0 : (tc_q == 3'h7 ? tc_q : tc_q + 3'h1);
			rc_q <= !rx_act ? 3'h0 : (rc_q == 3'h7 ? rc_q : rc_q + 3'h1);
			tx_wr <= tx_act && tc_q == (slow ? 3'h5 : 3'h1);
			rx_rd <= rx_act && rc_q == (slow ? 3'h5 : 3'h1);
		end
	end
endmodule

/* File: sim/sirq_top_tb_top.sv */
// Self-checking bench of the serial unit request logic
`timescale 1ns/100ps
module sirq_top_tb_top
	import sirq_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slv, standby, slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] ev;
	logic txe, tx_end_flag, rxf, rxe, vv, irq, sck, oen, tca, tcr, tw, rr;
	logic [1:0] vc;
	int err_count, num_checks;
	sirq_top DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .tx_data_empty_flag_set(ev[0]), .tx_end_flag_set(ev[1]), .rx_full_flag_set(ev[2]), .overrun_flag_set(ev[3]), .per_set(ev[4]),
		.fer_set(ev[5]), .tc_tx_write(tw), .tc_rx_read(rr), .standby_active(standby), .tx_empty_request(txe),
		.tx_end_request(tx_end_flag), .rx_full_request(rxf), .rx_error_request(rxe), .req_vec_valid(vv),
		.req_vec_code(vc), .tc_tx_activate(tca), .tc_rx_activate(tcr), .irq, .sck_o(sck), .sck_oe_n(oen));
	sirq_tc_model u_tc (.pclk, .presetn, .slow, .tx_act(tca), .rx_act(tcr), .tx_wr(tw), .rx_rd(rr));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	////////////////
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input logic [5:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 6'h00;
		wt(3);
	endtask
	task give_verdict;
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////
	task t_reset;
		apb(0, OFS_CTRL, 0);
		chk("ctrl", rd, {24'h0, CTL_RESET});
		apb(0, OFS_STATUS, 0);
		chk("status", rd, {26'h0, ST_RESET});
		apb(0, OFS_CLKDIV, 0);
		chk("clkdiv", rd, {24'h0, CLKDIV_RESET});
		apb(1, 8'h18, 32'hFF);
		chk("unmapped_err", slv, 1'b1);
		apb(0, 8'h18, 0);
		chk("unmapped_rd", rd, 32'h0);
		chk("pready", pready, 1'b1);
		chk("reqs_off", {txe, tx_end_flag, rxf, rxe}, 4'h0);
	endtask
	task t_tx;
		apb(1, OFS_CTRL, 32'h05);
		wt(3);
		chk("txe_tx_end_flag", {txe, tx_end_flag}, 2'h3);
		chk("vec_pins", {vv, vc}, {1'b1, VEC_TXE});
		apb(0, OFS_VECTOR, 0);
		chk("vec_txe", rd, {29'h0, 1'b1, VEC_TXE});
		apb(1, OFS_STATUS, 32'h03);
		wt(6);
		chk("tx_both_clr", {txe, tx_end_flag}, 2'h0);
		apb(1, OFS_CTRL, 32'h04);
		pulse(6'h02);
		chk("tx_end_flag_on", {txe, tx_end_flag}, 2'h1);
		apb(0, OFS_VECTOR, 0);
		chk("vec_tx_end_flag", rd, {29'h0, 1'b1, VEC_TX_END_FLAG});
		apb(1, OFS_CTRL, 32'h01);
		wt(3);
		chk("tx_end_flag_gate", tx_end_flag, 1'b0);
		pulse(6'h01);
		chk("txe_set", txe, 1'b1);
		apb(1, OFS_CTRL, 32'h00);
		wt(3);
		chk("txe_gate", txe, 1'b0);
		apb(1, OFS_STATUS, 32'h03);
	endtask
	task t_rx;
		apb(1, OFS_CTRL, 32'h02);
		pulse(6'h04);
		chk("rxf", rxf, 1'b1);
		for (int i = 3; i < 6; i++) begin
			pulse(6'h01 << i);
			chk("rxe", rxe, 1'b1);
			apb(0, OFS_VECTOR, 0);
			chk("vec_err", rd, {29'h0, 1'b1, VEC_ERR});
			apb(1, OFS_STATUS, 32'h38);
			wt(3);
			chk("rxe_clr", rxe, 1'b0);
		end
		pulse(6'h08);
		apb(1, OFS_CTRL, 32'h00);
		wt(3);
		chk("rx_gate", {rxe, rxf}, 2'h0);
		apb(1, OFS_IRQ_STAT, 32'hF);
		apb(1, OFS_IRQ_MASK, 32'h1);
		apb(1, OFS_CTRL, 32'h02);
		wt(4);
		chk("irq_on", irq, 1'b1);
		apb(1, OFS_IRQ_MASK, 32'h0);
		wt(3);
		chk("irq_mask", irq, 1'b0);
		apb(1, OFS_IRQ_MASK, 32'h1);
		wt(3);
		chk("irq_again", irq, 1'b1);
		apb(1, OFS_IRQ_STAT, 32'h1);
		wt(3);
		chk("irq_clr", irq, 1'b0);
		apb(1, OFS_STATUS, 32'h3C);
		apb(1, OFS_CTRL, 32'h00);
	endtask
	task t_tc(input logic s);
		slow <= s;
		apb(1, OFS_CTRL, 32'h63);
		pulse(6'h0D);
		wt(12);
		apb(0, OFS_STATUS, 0);
		chk("tc_status", rd, 32'h08);
		chk("tc_route", {txe, rxf, rxe, tca, tcr}, 5'b00100);
		apb(1, OFS_STATUS, 32'h08);
		apb(1, OFS_CTRL, 32'h00);
	endtask
	task t_clk;
		int n;
		@(posedge pclk);
		standby <= 1'b1;
		apb(1, OFS_CTRL, 32'h08);
		wt(20);
		chk("sck_standby", sck, 1'b0);
		chk("sck_oe_stby", oen, 1'b1);
		@(posedge pclk);
		standby <= 1'b0;
		apb(1, OFS_CTRL, 32'h08);
		n = 0;
		while (sck !== 1'b1 && n < 50) begin
			wt(1);
			n++;
		end
		chk("sck_oe", oen, 1'b0);
		chk("sck_first", n, {24'h0, CLKDIV_RESET} + 32'h1);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (sck === ~k[0] && n < 50) begin
				wt(1);
				n++;
			end
			chk("sck_half", n, {24'h0, CLKDIV_RESET});
		end
		apb(1, OFS_CTRL, 32'h00);
	endtask
	task t_ce;
		apb(1, OFS_CTRL, 32'h01);
		ce <= 1'b0;
		pulse(6'h01);
		apb(1, OFS_CTRL, 32'h00);
		wt(2);
		chk("ce_hold", txe, 1'b0);
		@(posedge pclk);
		ce <= 1'b1;
		pulse(6'h01);
		chk("ce_run", txe, 1'b1);
		apb(1, OFS_CTRL, 32'h00);
		apb(1, OFS_STATUS, 32'h01);
	endtask
	task t_rst;
		apb(1, OFS_CTRL, 32'h05);
		@(posedge pclk);
		presetn <= 1'b0;
		wt(3);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_CTRL, 0);
		chk("ctrl_rst", rd, {24'h0, CTL_RESET});
		apb(0, OFS_STATUS, 0);
		chk("status_rst", rd, {26'h0, ST_RESET});
		chk("reqs_rst", {txe, tx_end_flag, rxf, rxe, irq}, 5'h00);
	endtask
	////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 6'h00;
		standby = 1'b0;
		slow = 1'b0;
		ce = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_tx;
		t_rx;
		t_tc(1'b0);
		t_tc(1'b1);
		t_clk;
		t_ce;
		t_rst;
		give_verdict;
	end
	initial begin
		#500000;
		err_count++;
		give_verdict;
	end
endmodule
